/* File: rtl/bms_pkg.sv */
// Constants and types for the boot mode select and status blinker.
// Assumes a single 125 MHz clock and an AXI4-Lite register master.
package bms_pkg;
  localparam int unsigned BMS_CLK_HZ = 125_000_000;
  localparam int unsigned BMS_FAST_MS = 100;
  localparam int unsigned BMS_LONG_MS = 1000;
  localparam int unsigned BMS_SHORT_MS = 200;
  localparam int unsigned BMS_GAP_MS = 3000;
  localparam int unsigned BMS_RARP_MS = 1000;
  localparam int unsigned BMS_ADDR_W = 5;
  localparam logic [4:0] BMS_OFF_CTRL = 5'h00;
  localparam logic [4:0] BMS_OFF_STATUS = 5'h04;
  localparam logic [4:0] BMS_OFF_IP = 5'h08;
  localparam logic [4:0] BMS_OFF_IRQ_STAT = 5'h0c;
  localparam logic [4:0] BMS_OFF_IRQ_MASK = 5'h10;
  localparam int BMS_SW_FACTORY = 7;
  localparam int BMS_SW_MODIFY = 6;
  localparam int BMS_SW_STORED = 5;
  localparam int BMS_SW_MANUAL = 4;
  localparam int BMS_CTRL_ST_DONE = 0;
  localparam int BMS_CTRL_ST_PASS = 1;
  localparam int BMS_CTRL_REPORT = 2;
  localparam int BMS_CTRL_CODE_LSB = 8;
  localparam logic [31:0] BMS_CTRL_WMASK = 32'h00007f07;
  localparam logic [31:0] BMS_CTRL_RST = 32'h00000000;
  localparam int BMS_ST_SAMPLED = 8;
  localparam int BMS_ST_ASSIGNED = 9;
  localparam int BMS_ST_LED = 10;
  localparam int BMS_ST_CFG_LSB = 11;
  localparam int BMS_EV_ASSIGN = 0;
  localparam int BMS_EV_RARP = 1;
  localparam int BMS_EV_REFUSED = 2;
  localparam int BMS_EV_W = 3;
  localparam logic [1:0] BMS_RESP_OKAY = 2'h0;
  localparam logic [1:0] BMS_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic factory;
    logic modify;
    logic stored_ip;
    logic manual_ip;
  } bms_cfg_t;

  typedef enum logic [3:0] {
    IP_START = 4'b0001,
    IP_LOAD = 4'b0010,
    IP_NET = 4'b0100,
    IP_DONE = 4'b1000
  } bms_ip_st_t;

  typedef enum logic [6:0] {
    LS_FAST = 7'b0000001,
    LS_STEADY = 7'b0000010,
    LS_GAP = 7'b0000100,
    LS_LONG_ON = 7'b0001000,
    LS_LONG_OFF = 7'b0010000,
    LS_SHORT_ON = 7'b0100000,
    LS_SHORT_OFF = 7'b1000000
  } bms_led_st_t;
endpackage

/* File: rtl/bms_boot_status.sv */
// Boot mode decoding, address acquisition sequencing and status LED coder.
// Assumes an AXI4-Lite master, a firmware agent on the loose strobes and a
// switch bank that is steady when reset is released.
`timescale 1ns/1ps
module bms_boot_status
  import bms_pkg::*;
#(
  parameter int unsigned FAST_CYC = BMS_FAST_MS * (BMS_CLK_HZ / 1000),
  parameter int unsigned LONG_CYC = BMS_LONG_MS * (BMS_CLK_HZ / 1000),
  parameter int unsigned SHORT_CYC = BMS_SHORT_MS * (BMS_CLK_HZ / 1000),
  parameter int unsigned GAP_CYC = BMS_GAP_MS * (BMS_CLK_HZ / 1000),
  parameter int unsigned RARP_CYC = BMS_RARP_MS * (BMS_CLK_HZ / 1000)
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [BMS_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [BMS_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] dip_sw,
  output logic factory_test_mode,
  output logic modify_mode,
  input wire logic fw_prog_req,
  output logic fw_prog_grant,
  input wire logic subnet_wr_req,
  output logic subnet_wr_grant,
  output logic nv_rd_stb,
  input wire logic nv_rd_valid,
  input wire logic [31:0] nv_rd_ip,
  output logic nv_wr_stb,
  output logic [31:0] nv_wr_ip,
  input wire logic net_ip_valid,
  input wire logic [31:0] net_ip,
  output logic rarp_req,
  output logic ip_assigned,
  output logic led_on,
  output logic irq
);

  function automatic logic is_mapped(input logic [BMS_ADDR_W-1:0] a);
    return a == BMS_OFF_CTRL || a == BMS_OFF_STATUS || a == BMS_OFF_IP ||
           a == BMS_OFF_IRQ_STAT || a == BMS_OFF_IRQ_MASK;
  endfunction

  function automatic logic [31:0] strb_mask(input logic [3:0] s);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{s[i]}};
    end
    return m;
  endfunction

  function automatic logic [3:0] tens_of(input logic [6:0] c);
    logic [6:0] q;
    q = (c > 7'd99) ? 7'd9 : 7'(c / 7'd10);
    return q[3:0];
  endfunction

  function automatic logic [3:0] ones_of(input logic [6:0] c);
    logic [6:0] r;
    r = (c > 7'd99) ? 7'd9 : 7'(c % 7'd10);
    return r[3:0];
  endfunction

  // Switch capture.
  logic [7:0] sw_reg, sw_next;
  logic sampled_reg, sampled_next;
  bms_cfg_t cfg_reg, cfg_next;

  always_comb begin
    sw_next = sw_reg;
    cfg_next = cfg_reg;
    sampled_next = 1'b1;
    if (!sampled_reg) begin
      sw_next = dip_sw;
      cfg_next.factory = dip_sw[BMS_SW_FACTORY];
      cfg_next.modify = dip_sw[BMS_SW_MODIFY];
      cfg_next.stored_ip = dip_sw[BMS_SW_STORED];
      cfg_next.manual_ip = dip_sw[BMS_SW_MANUAL] & ~dip_sw[BMS_SW_STORED];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sw_reg <= 8'h00;
      cfg_reg <= '0;
      sampled_reg <= 1'b0;
    end else begin
      sw_reg <= sw_next;
      cfg_reg <= cfg_next;
      sampled_reg <= sampled_next;
    end
  end

  // Reserved switches are only reported, never decoded.
  assign factory_test_mode = cfg_reg.factory;
  assign modify_mode = cfg_reg.modify;
  assign fw_prog_grant = fw_prog_req & cfg_reg.modify;
  assign subnet_wr_grant = subnet_wr_req & cfg_reg.modify;

  // Address acquisition.
  bms_ip_st_t ip_st_reg, ip_st_next;
  logic [31:0] ip_reg, ip_next, nv_wr_ip_reg, nv_wr_ip_next, rt_reg, rt_next;
  logic rarp_reg, rarp_next, nv_rd_reg, nv_rd_next, nv_wr_reg, nv_wr_next;
  logic assigned_reg, assigned_next, ev_assign;

  always_comb begin
    ip_st_next = ip_st_reg;
    ip_next = ip_reg;
    nv_wr_ip_next = nv_wr_ip_reg;
    rt_next = rt_reg;
    rarp_next = 1'b0;
    nv_rd_next = 1'b0;
    nv_wr_next = 1'b0;
    assigned_next = assigned_reg;
    ev_assign = 1'b0;
    case (ip_st_reg)
      IP_START: begin
        if (sampled_reg) begin
          rt_next = '0;
          if (cfg_reg.stored_ip) begin
            ip_st_next = IP_LOAD;
            nv_rd_next = 1'b1;
          end else begin
            ip_st_next = IP_NET;
            rarp_next = !cfg_reg.manual_ip;
          end
        end
      end
      IP_LOAD: begin
        if (nv_rd_valid) begin
          ip_next = nv_rd_ip;
          ip_st_next = IP_DONE;
          assigned_next = 1'b1;
          ev_assign = 1'b1;
        end
      end
      IP_NET: begin
        rt_next = rt_reg + 32'd1;
        if (net_ip_valid) begin
          ip_next = net_ip;
          nv_wr_next = 1'b1;
          nv_wr_ip_next = net_ip;
          ip_st_next = IP_DONE;
          assigned_next = 1'b1;
          ev_assign = 1'b1;
        end else if (rt_reg == 32'(RARP_CYC - 1)) begin
          rt_next = '0;
          rarp_next = !cfg_reg.manual_ip;
        end
      end
      IP_DONE: begin
        // outside stored mode every later address is stored too
        if (!cfg_reg.stored_ip && net_ip_valid) begin
          ip_next = net_ip;
          nv_wr_next = 1'b1;
          nv_wr_ip_next = net_ip;
        end
      end
      default: ip_st_next = IP_START;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ip_st_reg <= IP_START;
      ip_reg <= 32'h00000000;
      nv_wr_ip_reg <= 32'h00000000;
      rt_reg <= 32'h00000000;
      rarp_reg <= 1'b0;
      nv_rd_reg <= 1'b0;
      nv_wr_reg <= 1'b0;
      assigned_reg <= 1'b0;
    end else begin
      ip_st_reg <= ip_st_next;
      ip_reg <= ip_next;
      nv_wr_ip_reg <= nv_wr_ip_next;
      rt_reg <= rt_next;
      rarp_reg <= rarp_next;
      nv_rd_reg <= nv_rd_next;
      nv_wr_reg <= nv_wr_next;
      assigned_reg <= assigned_next;
    end
  end

  assign rarp_req = rarp_reg;
  assign nv_rd_stb = nv_rd_reg;
  assign nv_wr_stb = nv_wr_reg;
  assign nv_wr_ip = nv_wr_ip_reg;
  assign ip_assigned = assigned_reg;

  // Register bus state.
  logic [31:0] ctrl_reg, ctrl_next, mask_reg, mask_next;
  logic [BMS_EV_W-1:0] irq_stat_reg, irq_stat_next, ev;
  logic aw_full_reg, aw_full_next, w_full_reg, w_full_next;
  logic [BMS_ADDR_W-1:0] aw_addr_reg, aw_addr_next;
  logic [31:0] w_data_reg, w_data_next, rdata_reg, rdata_next;
  logic [3:0] w_strb_reg, w_strb_next;
  logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] wmask, status_word, rd_word;
  logic wr_fire;

  // LED coder state, declared here for the status word.
  bms_led_st_t led_st_reg, led_st_next;
  logic led_reg, led_next;

  assign s_axi_awready = !aw_full_reg;
  assign s_axi_wready = !w_full_reg;
  assign s_axi_arready = !rvalid_reg;
  assign wr_fire = aw_full_reg && w_full_reg && !bvalid_reg;
  assign wmask = strb_mask(w_strb_reg);
  assign ev[BMS_EV_ASSIGN] = ev_assign;
  assign ev[BMS_EV_RARP] = rarp_next;
  assign ev[BMS_EV_REFUSED] = (fw_prog_req | subnet_wr_req) & ~cfg_reg.modify;

  always_comb begin
    status_word = '0;
    status_word[7:0] = sw_reg;
    status_word[BMS_ST_SAMPLED] = sampled_reg;
    status_word[BMS_ST_ASSIGNED] = assigned_reg;
    status_word[BMS_ST_LED] = led_reg;
    status_word[BMS_ST_CFG_LSB +: 4] = cfg_reg;
    case (s_axi_araddr)
      BMS_OFF_CTRL: rd_word = ctrl_reg;
      BMS_OFF_STATUS: rd_word = status_word;
      BMS_OFF_IP: rd_word = ip_reg;
      BMS_OFF_IRQ_STAT: rd_word = {29'h0, irq_stat_reg};
      BMS_OFF_IRQ_MASK: rd_word = mask_reg;
      default: rd_word = 32'h00000000;
    endcase
  end

  always_comb begin
    aw_full_next = aw_full_reg;
    aw_addr_next = aw_addr_reg;
    w_full_next = w_full_reg;
    w_data_next = w_data_reg;
    w_strb_next = w_strb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    ctrl_next = ctrl_reg;
    mask_next = mask_reg;
    irq_stat_next = irq_stat_reg;
    if (s_axi_awvalid && !aw_full_reg) begin
      aw_full_next = 1'b1;
      aw_addr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_full_reg) begin
      w_full_next = 1'b1;
      w_data_next = s_axi_wdata;
      w_strb_next = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (wr_fire) begin
      aw_full_next = 1'b0;
      w_full_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = is_mapped(aw_addr_reg) ? BMS_RESP_OKAY : BMS_RESP_SLVERR;
      if (aw_addr_reg == BMS_OFF_CTRL) begin
        ctrl_next = ((ctrl_reg & ~wmask) | (w_data_reg & wmask)) &
                    BMS_CTRL_WMASK;
      end
      if (aw_addr_reg == BMS_OFF_IRQ_MASK) begin
        mask_next = ((mask_reg & ~wmask) | (w_data_reg & wmask)) &
                    32'h00000007;
      end
      if (aw_addr_reg == BMS_OFF_IRQ_STAT) begin
        // Only a one in an enabled byte lane clears its flag.
        irq_stat_next = irq_stat_reg & ~(w_data_reg[BMS_EV_W-1:0] &
                        wmask[BMS_EV_W-1:0]);
      end
    end
    // New events win over a clear in the same cycle.
    irq_stat_next = irq_stat_next | ev;
    if (s_axi_rvalid && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    if (s_axi_arvalid && !rvalid_reg) begin
      rvalid_next = 1'b1;
      rdata_next = rd_word;
      rresp_next = is_mapped(s_axi_araddr) ? BMS_RESP_OKAY : BMS_RESP_SLVERR;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_full_reg <= 1'b0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= BMS_RESP_OKAY;
      rvalid_reg <= 1'b0;
      rresp_reg <= BMS_RESP_OKAY;
      rdata_reg <= 32'h00000000;
      ctrl_reg <= BMS_CTRL_RST;
      mask_reg <= 32'h00000000;
      irq_stat_reg <= '0;
    end else begin
      aw_full_reg <= aw_full_next;
      aw_addr_reg <= aw_addr_next;
      w_full_reg <= w_full_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
      ctrl_reg <= ctrl_next;
      mask_reg <= mask_next;
      irq_stat_reg <= irq_stat_next;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;
  assign irq = |(irq_stat_reg & mask_reg[BMS_EV_W-1:0]);

  // LED coder.
  logic [31:0] tmr_reg, tmr_next;
  logic [3:0] cnt_reg, cnt_next, tens_reg, tens_next, ones_reg, ones_next;
  logic report, ready;
  logic [6:0] code;

  assign report = ctrl_reg[BMS_CTRL_REPORT];
  assign ready = ctrl_reg[BMS_CTRL_ST_DONE] && ctrl_reg[BMS_CTRL_ST_PASS] &&
                 assigned_reg;
  assign code = ctrl_reg[BMS_CTRL_CODE_LSB +: 7];

  always_comb begin
    led_st_next = led_st_reg;
    tmr_next = tmr_reg + 32'd1;
    cnt_next = cnt_reg;
    tens_next = tens_reg;
    ones_next = ones_reg;
    led_next = led_reg;
    if (!report && led_st_reg != LS_FAST && led_st_reg != LS_STEADY) begin
      led_st_next = LS_FAST;
      tmr_next = '0;
      led_next = 1'b1;
    end else begin
      case (led_st_reg)
        LS_FAST, LS_STEADY: begin
          if (report) begin
            led_st_next = LS_GAP;
            tmr_next = '0;
            led_next = 1'b0;
            tens_next = tens_of(code);
            ones_next = ones_of(code);
          end else if (ready) begin
            led_st_next = LS_STEADY;
            tmr_next = '0;
            led_next = 1'b1;
          end else if (led_st_reg != LS_FAST) begin
            led_st_next = LS_FAST;
            tmr_next = '0;
            led_next = 1'b1;
          end else if (tmr_reg == 32'(FAST_CYC - 1)) begin
            tmr_next = '0;
            led_next = !led_reg;
          end
        end
        LS_GAP: begin
          if (tmr_reg == 32'(GAP_CYC - 1)) begin
            led_st_next = LS_LONG_ON;
            tmr_next = '0;
            cnt_next = '0;
            led_next = 1'b1;
          end
        end
        LS_LONG_ON: begin
          if (tmr_reg == 32'(LONG_CYC - 1)) begin
            led_st_next = LS_LONG_OFF;
            tmr_next = '0;
            led_next = 1'b0;
          end
        end
        LS_LONG_OFF: begin
          if (tmr_reg == 32'(LONG_CYC - 1)) begin
            tmr_next = '0;
            led_next = 1'b1;
            if (cnt_reg == tens_reg) begin
              led_st_next = LS_SHORT_ON;
              cnt_next = '0;
            end else begin
              led_st_next = LS_LONG_ON;
              cnt_next = cnt_reg + 4'd1;
            end
          end
        end
        LS_SHORT_ON: begin
          if (tmr_reg == 32'(SHORT_CYC - 1)) begin
            led_st_next = LS_SHORT_OFF;
            tmr_next = '0;
            led_next = 1'b0;
          end
        end
        LS_SHORT_OFF: begin
          if (tmr_reg == 32'(SHORT_CYC - 1)) begin
            tmr_next = '0;
            if (cnt_reg == ones_reg) begin
              led_st_next = LS_GAP;
              led_next = 1'b0;
              tens_next = tens_of(code);
              ones_next = ones_of(code);
            end else begin
              led_st_next = LS_SHORT_ON;
              cnt_next = cnt_reg + 4'd1;
              led_next = 1'b1;
            end
          end
        end
        default: begin
          led_st_next = LS_FAST;
          tmr_next = '0;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      led_st_reg <= LS_FAST;
      tmr_reg <= 32'h00000000;
      cnt_reg <= 4'h0;
      tens_reg <= 4'h0;
      ones_reg <= 4'h0;
      led_reg <= 1'b1;
    end else begin
      led_st_reg <= led_st_next;
      tmr_reg <= tmr_next;
      cnt_reg <= cnt_next;
      tens_reg <= tens_next;
      ones_reg <= ones_next;
      led_reg <= led_next;
    end
  end

  assign led_on = led_reg;

  AST_SW_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    sampled_reg |=> $stable(sw_reg) && $stable(cfg_reg))
    else $error("switch sample changed after capture");
  AST_DEFAULT: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(aresetn) |-> cfg_reg == '0 && !rarp_reg && led_reg)
    else $error("reset defaults wrong");
  AST_FACTORY: assert property (@(posedge aclk) disable iff (!aresetn)
    sampled_reg |-> factory_test_mode == sw_reg[BMS_SW_FACTORY])
    else $error("factory mode does not follow switch 8");
  AST_REFUSE: assert property (@(posedge aclk) disable iff (!aresetn)
    fw_prog_req && !modify_mode |-> !fw_prog_grant ##1
    irq_stat_reg[BMS_EV_REFUSED])
    else $error("firmware request not refused");
  AST_NV_WRITE: assert property (@(posedge aclk) disable iff (!aresetn)
    ip_st_reg == IP_NET && net_ip_valid |=>
    nv_wr_stb && nv_wr_ip == $past(net_ip) && ip_assigned)
    else $error("network address not stored");
  AST_NO_NET_WAIT: assert property (@(posedge aclk) disable iff (!aresetn)
    cfg_reg.stored_ip |-> ip_st_reg != IP_NET && !nv_wr_stb)
    else $error("stored mode waits for network");
  AST_RARP_FIRST: assert property (@(posedge aclk) disable iff (!aresetn)
    ip_st_reg == IP_START && sampled_reg && !cfg_reg.stored_ip &&
    !cfg_reg.manual_ip |=> rarp_req ##1 !rarp_req)
    else $error("first RARP request missing");
  AST_NO_RARP: assert property (@(posedge aclk) disable iff (!aresetn)
    cfg_reg.manual_ip || cfg_reg.stored_ip |-> !rarp_req)
    else $error("RARP sent while disabled");
  AST_STEADY: assert property (@(posedge aclk) disable iff (!aresetn)
    (!report && ready) ##1 (!report && ready) |-> led_on ##1 led_on)
    else $error("ready LED not steady");
  AST_GAP_DARK: assert property (@(posedge aclk) disable iff (!aresetn)
    led_st_reg == LS_GAP |-> !led_on)
    else $error("LED lit in gap");
  AST_TENS: assert property (@(posedge aclk) disable iff (!aresetn)
    led_st_reg == LS_LONG_ON |-> led_on && cnt_reg <= tens_reg)
    else $error("long flash count or level wrong");
  AST_SHORT_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
    led_st_reg == LS_SHORT_OFF |-> !led_on && cnt_reg <= ones_reg)
    else $error("short flash dark time wrong");

endmodule // bms_boot_status

/* File: testbench/bms_net_model.sv */
// Network and address store partner of the boot status block.
// Assumes one-cycle request strobes from the device on aclk.
`timescale 1ns/1ps
module bms_net_model (
  input wire logic aclk,
  input wire logic rarp_req,
  input wire logic nv_rd_stb,
  input wire logic nv_wr_stb,
  input wire logic [31:0] nv_wr_ip,
  input wire logic reply_en,
  input wire logic manual_go,
  input wire logic [31:0] srv_ip,
  output logic nv_rd_valid,
  output logic [31:0] nv_rd_ip,
  output logic net_ip_valid,
  output logic [31:0] net_ip,
  output logic [31:0] nv_mem
);
  int dly = 0;
  initial begin
    nv_rd_valid = 0;
    net_ip_valid = 0;
    nv_rd_ip = 0;
    net_ip = 0;
    nv_mem = 32'h0a0b0c0d;
  end
  // Idle data lines flip every cycle so a stale value never passes.
  always @(posedge aclk) begin
    nv_rd_valid <= nv_rd_stb;
    nv_rd_ip <= nv_rd_stb ? nv_mem : ~nv_rd_ip;
    if (nv_wr_stb)
      nv_mem <= nv_wr_ip;
    dly <= (rarp_req && reply_en) ? 5 : (dly > 0 ? dly - 1 : 0);
    net_ip_valid <= (dly == 1) || manual_go;
    net_ip <= ((dly == 1) || manual_go) ? srv_ip : ~net_ip;
  end
endmodule // bms_net_model

/* File: testbench/bms_boot_status_bench.sv */
// Self-checking bench of the boot mode and status blinker.
// Assumes the rtl files and the network partner model.
`timescale 1ns/1ps
module bms_boot_status_bench;
  import bms_pkg::*;
  localparam int LC = 10;
  localparam int SC = 3;
  localparam int GC = 20;
  typedef struct packed {
    logic [7:0] sw;
    logic fac, mod, rarp, nvrd;
  } bms_row_t;
  // Every row keeps the reserved switches 1 to 4 off.
  bms_row_t tab [6] = '{'{8'h00, 0, 0, 1, 0}, '{8'h80, 1, 0, 1, 0},
    '{8'h40, 0, 1, 1, 0}, '{8'h20, 0, 0, 0, 1}, '{8'h30, 0, 0, 0, 1},
    '{8'h10, 0, 0, 0, 0}};
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, fw_prog_req = 1, subnet_wr_req = 1;
  logic reply_en = 0, manual_go = 0, p;
  logic awready, wready, bvalid, arready, rvalid, factory_test_mode;
  logic modify_mode, fw_prog_grant, subnet_wr_grant, nv_rd_stb, irq;
  logic nv_rd_valid, nv_wr_stb, net_ip_valid, rarp_req, ip_assigned, led_on;
  logic [4:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, srv_ip = 0, rdata, nv_rd_ip, net_ip, nv_wr_ip;
  logic [31:0] nv_mem, d;
  logic [3:0] wstrb = 4'hf;
  logic [1:0] bresp, rresp, r;
  logic [7:0] dip_sw = 0;
  int miscompares = 0, checks_done = 0, cyc = 0, nr, nd, t;
  int codes [4] = '{0, 11, 42, 99};
  always #4 aclk = ~aclk;
  bms_boot_status #(.FAST_CYC(4), .LONG_CYC(LC), .SHORT_CYC(SC),
    .GAP_CYC(GC), .RARP_CYC(16)) u_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .dip_sw(dip_sw),
    .factory_test_mode(factory_test_mode), .modify_mode(modify_mode),
    .fw_prog_req(fw_prog_req), .fw_prog_grant(fw_prog_grant),
    .subnet_wr_req(subnet_wr_req), .subnet_wr_grant(subnet_wr_grant),
    .nv_rd_stb(nv_rd_stb), .nv_rd_valid(nv_rd_valid), .nv_rd_ip(nv_rd_ip),
    .nv_wr_stb(nv_wr_stb), .nv_wr_ip(nv_wr_ip), .net_ip_valid(net_ip_valid),
    .net_ip(net_ip), .rarp_req(rarp_req), .ip_assigned(ip_assigned),
    .led_on(led_on), .irq(irq));
  bms_net_model u_net (.aclk(aclk), .rarp_req(rarp_req),
    .nv_rd_stb(nv_rd_stb), .nv_wr_stb(nv_wr_stb), .nv_wr_ip(nv_wr_ip),
    .reply_en(reply_en), .manual_go(manual_go), .srv_ip(srv_ip),
    .nv_rd_valid(nv_rd_valid), .nv_rd_ip(nv_rd_ip),
    .net_ip_valid(net_ip_valid), .net_ip(net_ip), .nv_mem(nv_mem));
  task summarize;
    if (miscompares == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      miscompares++;
      summarize();
    end
  end
  task boot(input logic [7:0] s);
    @(posedge aclk);
    aresetn <= 0;
    dip_sw <= s;
    repeat (12) @(posedge aclk);
    aresetn <= 1;
  endtask
  task axw(input logic [4:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid);
    r = bresp;
    bready <= 0;
  endtask
  task axr(input logic [4:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 0;
  endtask
  // Counts requests; the mode switches flip after the sixth sample to prove the latch.
  task cnt(input int n);
    nr = 0;
    nd = 0;
    for (int k = 0; k < n; k++) begin
      @(negedge aclk);
      nr += rarp_req;
      nd += nv_rd_stb;
      if (k == 5) begin
        @(posedge aclk);
        dip_sw <= dip_sw ^ 8'hf0;
      end
    end
  endtask
  // Waits for a last short dark time plus a full gap, so that the new code
  // is latched, then classifies every lit and dark run.
  task blink(input int code);
    int lo, h, l, nl, ns, bad;
    axw(BMS_OFF_CTRL, 32'h7 | (code << 8));
    lo = 0;
    while (lo < GC + SC) begin
      @(negedge aclk);
      lo = led_on ? 0 : lo + 1;
    end
    {h, l, nl, ns, bad} = '0;
    while (l < GC) begin
      @(negedge aclk);
      if (led_on) begin
        if (l > 0) begin
          bad += (l != h);
          {h, l} = '0;
        end
        h++;
      end else begin
        if (l == 0) begin
          bad += (h != LC && h != SC) || (ns > 0 && h == LC);
          nl += (h == LC);
          ns += (h == SC);
        end
        l++;
      end
    end
    chk(nl, code / 10 + 1);
    chk(ns, code % 10 + 1);
    chk(bad, 0);
  endtask
  initial begin
    foreach (tab[i]) begin
      boot(tab[i].sw);
      cnt(40);
      chk(factory_test_mode, tab[i].fac);
      chk(modify_mode, tab[i].mod);
      chk(fw_prog_grant, tab[i].mod);
      chk(subnet_wr_grant, tab[i].mod);
      chk(nr >= 2, tab[i].rarp);
      chk(nd, tab[i].nvrd);
    end
    @(posedge aclk);
    fw_prog_req <= 0;
    subnet_wr_req <= 0;
    reply_en <= 1;
    srv_ip <= 32'hc0a80107;
    boot(8'h00);
    axr(BMS_OFF_CTRL);
    chk(d, BMS_CTRL_RST);
    axr(5'h14);
    chk({r, d[29:0]}, {BMS_RESP_SLVERR, 30'h0});
    axw(BMS_OFF_IRQ_MASK, 32'h1);
    chk(r, BMS_RESP_OKAY);
    t = 0;
    p = led_on;
    repeat (24) begin
      @(negedge aclk);
      t += (led_on != p);
      p = led_on;
    end
    chk(t >= 4, 1);
    while (!ip_assigned) @(negedge aclk);
    repeat (2) @(negedge aclk);
    chk(nv_mem, 32'hc0a80107);
    chk(irq, 1);
    cnt(40);
    chk(nr, 0);
    axw(BMS_OFF_IRQ_STAT, 32'h1);
    chk(irq, 0);
    axr(BMS_OFF_IRQ_STAT);
    chk(d[2:0], 3'h2);
    srv_ip <= 32'h0a000063;
    manual_go <= 1;
    @(posedge aclk);
    manual_go <= 0;
    repeat (3) @(negedge aclk);
    chk(nv_mem, 32'h0a000063);
    axw(BMS_OFF_CTRL, 32'h3);
    t = 0;
    repeat (30) @(negedge aclk) t += !led_on;
    chk(t, 0);
    foreach (codes[i]) blink(codes[i]);
    @(posedge aclk);
    reply_en <= 0;
    fw_prog_req <= 1;
    boot(8'h20);
    while (!ip_assigned) @(negedge aclk);
    axr(BMS_OFF_IP);
    chk(d, 32'h0a000063);
    axr(BMS_OFF_IRQ_STAT);
    chk(d[2:0], 3'h5);
    chk(irq, 0);
    summarize();
  end
endmodule // bms_boot_status_bench
